// File: design/sew_pkg.sv
// Shared constants and types of the serial EEPROM write path.
// Assumes a 40 MHz core clock and a free link sampling clock.
package sew_pkg;
   // ************************************************************
   // Array geometry
   // ************************************************************
   localparam int PAGES = 128;
   localparam int PAGE_BYTES = 16;
   localparam int MEM_BYTES = PAGES * PAGE_BYTES;
   localparam int ADDR_W = 11;
   localparam int OFS_W = 4;
   localparam int ROW_W = 7;
   localparam int BYTE_W = 8;
   // ************************************************************
   // Device address byte layout
   // ************************************************************
   // Type code value is arbitrary
   localparam logic [3:0] TYPE_ID = 4'h5;
   localparam int DEV_TYPE_MSB = 7;
   localparam int DEV_TYPE_LSB = 4;
   localparam int DEV_HI_MSB = 3;
   localparam int DEV_HI_LSB = 1;
   localparam int DEV_RW_BIT = 0;
   // ************************************************************
   // Bit slots within one nine-clock byte frame
   // ************************************************************
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CORE_CLK_MHZ = 40;
   localparam int PROG_TIME_US_DEF = 1000;
   localparam int TIMER_W = 24;
   // ************************************************************
   // States
   // ************************************************************
   typedef enum logic [2:0] {
      SEW_IDLE = 3'h0,
      SEW_DEV = 3'h1,
      SEW_WORD = 3'h3,
      SEW_DATA = 3'h2,
      SEW_READ = 3'h6,
      SEW_SKIP = 3'h7
   } sew_link_state_t;
   typedef enum logic {
      SEW_E_IDLE = 1'b0,
      SEW_E_PROG = 1'b1
   } sew_eng_state_t;
endpackage : sew_pkg

// File: design/sew_prog_if.sv
// Handshake and page transfer between the link side and the program engine.
// Link holds row, data and mask stable while req_tgl differs from ack_tgl.
`timescale 1ns/10ps
`default_nettype none
interface sew_prog_if;
   import sew_pkg::*;
   logic req_tgl;
   logic ack_tgl;
   logic [ROW_W-1:0] row;
   logic [PAGE_BYTES-1:0][BYTE_W-1:0] data;
   logic [PAGE_BYTES-1:0] mask;
   logic [ADDR_W-1:0] rd_addr;
   logic [BYTE_W-1:0] rd_data;
   modport link (output req_tgl, row, data, mask, rd_addr, input ack_tgl, rd_data);
   modport engine (input req_tgl, row, data, mask, rd_addr, output ack_tgl, rd_data);
endinterface : sew_prog_if
`default_nettype wire

// File: design/sew_prog_engine.sv
// Core-domain program engine: write timer and the flip-flop array.
// Assumes a synchronised active-low reset and a toggle request from the link.
`timescale 1ns/10ps
`default_nettype none
module sew_prog_engine import sew_pkg::*; #(
   parameter logic [TIMER_W-1:0] PROG_CYCLES = TIMER_W'(PROG_TIME_US_DEF * CORE_CLK_MHZ)
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   sew_prog_if.engine prog
);
   logic req_meta;
   logic req_sync;
   logic req_seen;
   logic ack;
   logic [TIMER_W-1:0] timer;
   sew_eng_state_t state;
   logic [BYTE_W-1:0] mem [MEM_BYTES];
   wire new_req = req_sync != req_seen;
   wire done = (state == SEW_E_PROG) && (timer == '0);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end else begin
         req_meta <= prog.req_tgl;
         req_sync <= req_meta;
      end
   end

   // ************************************************************
   // Self-timed cycle; busy ends only when the timer runs out
   // ************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= SEW_E_IDLE;
         timer <= '0;
         req_seen <= 1'b0;
         ack <= 1'b0;
      end else begin
         unique case (state)
            SEW_E_IDLE: begin
               if (new_req) begin
                  state <= SEW_E_PROG;
                  timer <= PROG_CYCLES - 1'b1;
                  req_seen <= req_sync;
               end
            end
            SEW_E_PROG: begin
               if (done) begin
                  state <= SEW_E_IDLE;
                  ack <= ~ack;
               end else begin
                  timer <= timer - 1'b1;
               end
            end
         endcase
      end
   end

   // Whole page lands in one cycle; unloaded bytes keep their old value
   always_ff @(posedge clk_in) begin
      if (done) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (prog.mask[i]) begin
               mem[{prog.row, OFS_W'(i)}] <= prog.data[i];
            end
         end
      end
   end

   assign prog.ack_tgl = ack;
   // Read path is quasi-static: array changes only inside a handshake
   assign prog.rd_data = mem[prog.rd_addr];
endmodule : sew_prog_engine
`default_nettype wire

// File: design/sew_top.sv
// Two-wire EEPROM client: address decode, byte and page write, polling.
// Assumes open-drain SDA resolved outside and a free link sampling clock.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Array is 128 pages of 16 bytes
// - First byte after Start selects the device
// - Respond only when type code matches
// - Address byte bits 3..1 give upper address
// - Bit 0 high reads, low writes
// - Acknowledge a match, otherwise no acknowledge
// - Word address byte gives low eight bits
// - Acknowledge address, word and data bytes
// - Stop after write starts timed programming
// - Ignore array access while programming
// - Page write programs up to 16 bytes
// - Host may send fifteen more bytes
// - Only low four address bits increment, wrapping; the read counter here steps all 11 bits
// - Withhold acknowledge while programming, then acknowledge
// - Protect pin high blocks all writes
// - Protect pin sampled at the Stop
// - Protected write acknowledged but never programmed
// - Address counter holds last address plus one
// - Capture on clock rise, change on fall
module sew_top import sew_pkg::*; #(
   parameter int PROG_TIME_US = PROG_TIME_US_DEF
) (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   output logic sda_out,
   output logic sda_oe_out
);
   localparam logic [TIMER_W-1:0] PROG_CYCLES = TIMER_W'(PROG_TIME_US * CORE_CLK_MHZ);

   // ************************************************************
   // Resets and synchronisers
   // ************************************************************
   logic rst_c_meta;
   logic rst_c_n;
   logic rst_l_meta;
   logic rst_l_n;
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic scl_q;
   logic sda_q;
   logic ack_meta;
   logic ack_sync;
   // Carrier to the core-domain engine, declared before any use of it
   sew_prog_if prog ();

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_c_meta <= 1'b0;
         rst_c_n <= 1'b0;
      end else begin
         rst_c_meta <= 1'b1;
         rst_c_n <= rst_c_meta;
      end
   end

   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_l_meta <= 1'b0;
         rst_l_n <= 1'b0;
      end else begin
         rst_l_meta <= 1'b1;
         rst_l_n <= rst_l_meta;
      end
   end

   // Protect pin idles low after reset; the bus pins SDA and SCL idle high
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         pin_meta <= 3'h3;
         pin_sync <= 3'h3;
      end else begin
         pin_meta <= {wp_in, sda_in, scl_in};
         pin_sync <= pin_meta;
      end
   end

   // History of the synced pins; idles high so reset makes no false edge
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= pin_sync[0];
         sda_q <= pin_sync[1];
      end
   end

   // Engine answer is a toggle, so a plain two-flop copy is safe
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         ack_meta <= prog.ack_tgl;
         ack_sync <= ack_meta;
      end
   end

   // ************************************************************
   // Bus event decode
   // ************************************************************
   sew_link_state_t state;
   sew_link_state_t next_state;
   logic [3:0] bit_cnt;
   logic [BYTE_W-1:0] rx_sh;
   logic [BYTE_W-1:0] tx_sh;
   logic ack_pend;
   logic rd_started;
   logic req_tgl;
   logic [DEV_HI_MSB-DEV_HI_LSB:0] hi_addr;
   logic [ADDR_W-1:0] addr_ctr;
   logic [PAGE_BYTES-1:0][BYTE_W-1:0] pbuf;
   logic [PAGE_BYTES-1:0] mask;

   wire scl_s = pin_sync[0];
   wire sda_s = pin_sync[1];
   wire wp_s = pin_sync[2];
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
   wire byte_done = scl_rise && (bit_cnt == BIT_LAST);
   wire ack_rise = scl_rise && (bit_cnt == BIT_ACK);
   wire [BYTE_W-1:0] rx_byte = {rx_sh[BYTE_W-2:0], sda_s};
   // Busy from the request toggle until the engine answers it
   wire busy = req_tgl != ack_sync;
   wire type_ok = rx_byte[DEV_TYPE_MSB:DEV_TYPE_LSB] == TYPE_ID;
   wire dev_match = type_ok && !busy;
   wire is_read = rx_byte[DEV_RW_BIT];
   wire rd_next = ack_rise && (state == SEW_READ) && rd_started;
   wire in_write = (state == SEW_WORD) || (state == SEW_DATA);
   wire [OFS_W-1:0] ofs = addr_ctr[OFS_W-1:0];
   wire [OFS_W-1:0] ofs_inc = ofs + 1'b1;
   wire [ADDR_W-1:0] addr_inc = addr_ctr + 1'b1;
   wire do_program = stop_cond && (state == SEW_DATA) && (|mask) && !wp_s;

   // ************************************************************
   // Sequence state
   // ************************************************************
   always_comb begin
      next_state = state;
      if (start_cond) begin
         next_state = SEW_DEV;
      end else if (stop_cond) begin
         next_state = SEW_IDLE;
      end else if (byte_done) begin
         unique case (state)
            SEW_DEV: begin
               if (!dev_match) begin
                  next_state = SEW_SKIP;
               end else if (is_read) begin
                  next_state = SEW_READ;
               end else begin
                  next_state = SEW_WORD;
               end
            end
            SEW_WORD: next_state = SEW_DATA;
            SEW_IDLE, SEW_DATA, SEW_READ, SEW_SKIP: next_state = state;
         endcase
      end else if (rd_next && sda_s) begin
         next_state = SEW_SKIP;
      end
   end

   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         state <= SEW_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Bit framing
   // ************************************************************
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         bit_cnt <= BIT_FIRST;
         rx_sh <= '0;
      end else if (start_cond) begin
         bit_cnt <= BIT_FIRST;
      end else if (scl_rise) begin
         bit_cnt <= (bit_cnt == BIT_ACK) ? BIT_FIRST : bit_cnt + 1'b1;
         rx_sh <= rx_byte;
      end
   end

   // Decision taken at the eighth rise, driven at the following fall
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         ack_pend <= 1'b0;
      end else if (start_cond || ack_rise) begin
         ack_pend <= 1'b0;
      end else if (byte_done) begin
         ack_pend <= (state == SEW_DEV) ? dev_match : in_write;
      end
   end

   // ************************************************************
   // Open-drain output: change on the clock fall, release at Start or Stop
   // ************************************************************
   wire pin_release = start_cond || stop_cond;
   wire ack_slot = bit_cnt == BIT_ACK;
   wire rd_load = (state == SEW_READ) && (bit_cnt == BIT_FIRST);
   wire rd_shift = (state == SEW_READ) && rd_started;
   wire [BYTE_W-1:0] rd_word = prog.rd_data;

   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (pin_release) begin
         sda_oe_out <= 1'b0;
      end else if (scl_fall) begin
         if (ack_slot) begin
            sda_oe_out <= ack_pend;
         end else if (rd_load) begin
            sda_oe_out <= ~rd_word[BYTE_W-1];
         end else if (rd_shift) begin
            sda_oe_out <= ~tx_sh[BYTE_W-1];
         end else begin
            sda_oe_out <= 1'b0;
         end
      end
   end

   // Read shifter fills with ones so a released bit reads high
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         tx_sh <= '1;
         rd_started <= 1'b0;
      end else if (pin_release) begin
         rd_started <= 1'b0;
      end else if (scl_fall && !ack_slot) begin
         if (rd_load) begin
            tx_sh <= {rd_word[BYTE_W-2:0], 1'b1};
            rd_started <= 1'b1;
         end else if (rd_shift) begin
            tx_sh <= {tx_sh[BYTE_W-2:0], 1'b1};
         end
      end
   end

   // ************************************************************
   // Address counter
   // ************************************************************
   // Survives between operations; only reset clears it
   wire dev_take = byte_done && (state == SEW_DEV) && dev_match;
   wire word_take = byte_done && (state == SEW_WORD);
   wire data_take = byte_done && (state == SEW_DATA);
   wire [ADDR_W-1:0] page_next = {addr_ctr[ADDR_W-1:OFS_W], ofs_inc};

   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         hi_addr <= '0;
      end else if (dev_take) begin
         hi_addr <= rx_byte[DEV_HI_MSB:DEV_HI_LSB];
      end
   end

   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         addr_ctr <= '0;
      end else if (word_take) begin
         addr_ctr <= {hi_addr, rx_byte};
      end else if (data_take) begin
         addr_ctr <= page_next;
      end else if (rd_next) begin
         addr_ctr <= addr_inc;
      end
   end

   // ************************************************************
   // Page buffer and program request
   // ************************************************************
   // Buffer is frozen while busy, so the engine may read it across domains
   wire mask_clear = start_cond && !busy;

   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         pbuf <= '0;
      end else if (data_take) begin
         pbuf[ofs] <= rx_byte;
      end
   end

   // A wrapped byte overwrites its slot; the mask only records presence
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         mask <= '0;
      end else if (mask_clear) begin
         mask <= '0;
      end else if (data_take) begin
         mask[ofs] <= 1'b1;
      end
   end

   // Protected or empty writes end at Stop with no cycle at all
   always_ff @(posedge link_clk_in or negedge rst_l_n) begin
      if (!rst_l_n) begin
         req_tgl <= 1'b0;
      end else if (do_program) begin
         req_tgl <= ~req_tgl;
      end
   end

   assign prog.req_tgl = req_tgl;
   assign prog.row = addr_ctr[ADDR_W-1:OFS_W];
   assign prog.data = pbuf;
   assign prog.mask = mask;
   assign prog.rd_addr = addr_ctr;

   // ************************************************************
   // Program engine in the core domain
   // ************************************************************
   sew_prog_engine #(
      .PROG_CYCLES(PROG_CYCLES)
   ) u_engine (
      .clk_in(core_clk_in),
      .rst_n_in(rst_c_n),
      .prog(prog)
   );
endmodule : sew_top
`default_nettype wire

// File: dv/sew_top_props.sv
// Pin-level checker for sew_top, bound into every instance.
// Assumes the host holds each SCL phase for several link clocks.
`timescale 1ns/10ps
`default_nettype none
module sew_top_props import sew_pkg::*; (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   input wire logic sda_out,
   input wire logic sda_oe_out
);
   // ****
   // Frame tracking on the raw pins
   // ****
   logic scl_q, sda_q, rw, miss, idle;
   logic [3:0] cnt;
   logic [3:0] nbyte;
   logic [7:0] sh;
   wire rise = scl_in && !scl_q;
   wire start = scl_in && scl_q && sda_q && !sda_in;
   wire stop = scl_in && scl_q && !sda_q && sda_in;
   wire slot9 = rise && cnt == BIT_ACK;
   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {scl_q, sda_q, idle, miss, rw} <= 5'h1c;
         {cnt, nbyte, sh} <= '0;
      end else begin
         {scl_q, sda_q} <= {scl_in, sda_in};
         if (start) begin
            {cnt, nbyte, miss, idle} <= '0;
         end else if (stop) begin
            idle <= 1'b1;
         end else if (slot9) begin
            cnt <= '0;
            // Saturates so long page writes keep reading as data bytes
            nbyte <= nbyte + {3'h0, nbyte != 4'hf};
            if (nbyte == 4'h0) begin
               {miss, rw} <= {sh[7:4] != TYPE_ID, sh[0]};
            end
         end else if (rise) begin
            cnt <= cnt + 4'h1;
            sh <= {sh[6:0], sda_in};
         end
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge link_clk_in);
   endclocking
   default disable iff (!nrst_in);
   a_drive_zero: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_oe_scl_low: assert property (
      $changed(sda_oe_out) |-> !scl_in && !scl_q)
      else $error("data changed while clock high");
   a_miss_nack: assert property (
      slot9 && nbyte == 4'h0 && sh[7:4] != TYPE_ID |-> !sda_oe_out)
      else $error("ack given to foreign type code");
   a_miss_silent: assert property (miss |-> !sda_oe_out)
      else $error("drive after foreign address");
   a_host_bits: assert property (
      rise && cnt < BIT_ACK && (nbyte == 4'h0 || !rw) |-> !sda_oe_out)
      else $error("drive during host bit");
   a_rd_host_ack: assert property (
      slot9 && nbyte != 4'h0 && rw |-> !sda_oe_out)
      else $error("drive during host ack slot");
   a_idle_quiet: assert property (idle |-> !sda_oe_out)
      else $error("drive while bus idle");
   a_ack_width: assert property (
      $rose(sda_oe_out) && (nbyte == 4'h0 ? !sh[0] : !rw)
      |-> sda_oe_out [*8] ##[1:20] !sda_oe_out)
      else $error("ack pulse not one bit long");
   c_dev_ack: cover property (slot9 && nbyte == 4'h0 && sda_oe_out);
   c_dev_miss: cover property (slot9 && nbyte == 4'h0 && sh[7:4] != TYPE_ID);
   c_rd_nack: cover property (slot9 && nbyte != 4'h0 && rw && sda_in);
   c_stop: cover property (stop);
endmodule : sew_top_props
bind sew_top sew_top_props u_props (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
   .link_clk_in(link_clk_in), .scl_in(scl_in), .sda_in(sda_in), .wp_in(wp_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire

// File: dv/sew_host_model.sv
// Two-wire bus host model, stepping on falling core clock edges.
// Assumes the bench resolves SDA with a pull-up; SCL stands high when idle.
`timescale 1ns/10ps
`default_nettype none
module sew_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   initial begin
      {scl_out, sda_oe_out} = 2'h2;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge clk_in);
   endtask : gap
   // Leading gap keeps SDA from moving in the step SCL falls
   task automatic start_bit();
      gap(2);
      sda_oe_out = 1'b0;
      gap(2);
      scl_out = 1'b1;
      gap(2);
      sda_oe_out = 1'b1;
      gap(2);
      scl_out = 1'b0;
   endtask : start_bit
   task automatic stop_bit();
      gap(2);
      sda_oe_out = 1'b1;
      gap(2);
      scl_out = 1'b1;
      gap(2);
      sda_oe_out = 1'b0;
      gap(2);
   endtask : stop_bit
   task automatic bit_io(input logic b, output logic r);
      gap(2);
      sda_oe_out = !b;
      gap(2);
      scl_out = 1'b1;
      gap(4);
      r = sda_in;
      scl_out = 1'b0;
   endtask : bit_io
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : put_byte
   task automatic get_byte(output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(1'b1, r);
   endtask : get_byte
endmodule : sew_host_model
`default_nettype wire

// File: dv/serial_eeprom_address_write_bench.sv
// Self-checking bench for sew_top driven through the host model.
// Assumes a short program time so that polling sees one refusal.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_address_write_bench import sew_pkg::*;;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic nrst = 1'b0;
   logic wp = 1'b0;
   int num_errors = 0;
   int tests_run = 0;
   wire scl, host_oe, dev_oe, dev_dq;
   wire sda = ~(dev_oe | host_oe);
   initial forever #12.5 core_clk = ~core_clk;
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   sew_top #(.PROG_TIME_US(3)) uut (.core_clk_in(core_clk), .nrst_in(nrst),
      .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda), .wp_in(wp),
      .sda_out(dev_dq), .sda_oe_out(dev_oe));
   sew_host_model host (.clk_in(core_clk), .sda_in(sda), .scl_out(scl),
      .sda_oe_out(host_oe));
   // ****
   // Shared tasks
   // ****
   task automatic close_out();
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic check_ack(input logic got, input logic exp);
      check({7'h0, got}, {7'h0, exp});
   endtask : check_ack
   function automatic logic [7:0] dbyte(input logic [2:0] hi, input logic rw);
      return {TYPE_ID, hi, rw};
   endfunction : dbyte
   task automatic send(input logic [7:0] b, input logic exp);
      logic a;
      host.put_byte(b, a);
      check_ack(a, exp);
   endtask : send
   task automatic write_page(input logic [10:0] ad, input int n, input logic [7:0] v);
      host.start_bit();
      send(dbyte(ad[10:8], 1'b0), 1'b1);
      send(ad[7:0], 1'b1);
      for (int i = 0; i < n; i++) begin
         send(v + 8'(i), 1'b1);
      end
      host.stop_bit();
   endtask : write_page
   task automatic wait_ready(input logic first);
      logic a = 1'b0;
      for (int i = 0; i < 12 && !a; i++) begin
         host.start_bit();
         host.put_byte(dbyte(3'h0, 1'b0), a);
         if (i == 0) check_ack(a, first);
      end
      host.stop_bit();
      if (a !== 1'b1) begin
         $display("unexpected at %0t: device never ready", $time);
         num_errors++;
         close_out();
      end
   endtask : wait_ready
   task automatic read_at(input logic [10:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      host.start_bit();
      send(dbyte(ad[10:8], 1'b0), 1'b1);
      send(ad[7:0], 1'b1);
      host.start_bit();
      send(dbyte(ad[10:8], 1'b1), 1'b1);
      host.get_byte(d);
      check(d, exp);
      host.stop_bit();
   endtask : read_at
   task automatic read_cur(input logic [7:0] exp);
      logic [7:0] d;
      host.start_bit();
      send(dbyte(3'h0, 1'b1), 1'b1);
      host.get_byte(d);
      check(d, exp);
      host.stop_bit();
   endtask : read_cur
   // ****
   // Scenarios
   // ****
   task automatic sc_miss();
      for (int k = 0; k < 4; k++) begin
         host.start_bit();
         send({TYPE_ID ^ (4'h1 << k), 4'h0}, 1'b0);
         send(8'h00, 1'b0);
      end
      host.stop_bit();
   endtask : sc_miss
   task automatic sc_page();
      write_page(11'h530, 16, 8'ha0);
      wait_ready(1'b0);
      read_cur(8'ha0);
      read_at(11'h53f, 8'haf);
   endtask : sc_page
   task automatic sc_wrap();
      write_page(11'h53f, 3, 8'h50);
      wait_ready(1'b0);
      read_cur(8'ha2);
      read_at(11'h530, 8'h51);
      read_cur(8'h52);
   endtask : sc_wrap
   task automatic sc_abort();
      host.start_bit();
      send(dbyte(3'h5, 1'b0), 1'b1);
      send(8'h30, 1'b1);
      send(8'h11, 1'b1);
      wait_ready(1'b1);
      read_at(11'h530, 8'h51);
   endtask : sc_abort
   task automatic sc_protect();
      write_page(11'h235, 1, 8'h66);
      host.gap(4);
      wp = 1'b1;
      wait_ready(1'b0);
      write_page(11'h235, 1, 8'h99);
      wait_ready(1'b1);
      wp = 1'b0;
      read_at(11'h235, 8'h66);
      read_at(11'h535, 8'ha5);
   endtask : sc_protect
   initial begin
      repeat (16) @(negedge core_clk);
      nrst = 1'b1;
      repeat (8) @(negedge core_clk);
      sc_miss();
      sc_page();
      sc_wrap();
      sc_abort();
      sc_protect();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      $display("unexpected at %0t: run too long", $time);
      num_errors++;
      close_out();
   end
endmodule : serial_eeprom_address_write_bench
`default_nettype wire
